// *** rtl/tap_pkg.sv ***
// Package for the scan-test access port timing block.
// Assumes one system clock CLK at 200 MHz that oversamples the test clock.
`default_nettype none
package tap_pkg;

    localparam int IR_LEN = 8;
    localparam logic [7:0] IR_CAPTURE = 8'h81;
    localparam logic [7:0] IR_BYPASS = 8'hff;
    localparam logic [7:0] IR_RESET = 8'hff;
    localparam int DR_LEN = 8;
    localparam logic [7:0] DR_RESET = 8'h00;
    localparam logic BYPASS_CAPTURE = 1'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } tap_state_t;

    // Test-side pins after synchronisation
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    // Edge events of the test clock, one CLK cycle wide
    typedef struct packed {
        logic rise;
        logic fall;
    } tck_edges_t;

endpackage : tap_pkg
`default_nettype wire

// *** rtl/tap_sync.sv ***
// Two-flop synchroniser for the test pins plus test clock edge finder.
// Assumes the pins are asynchronous to CLK and much slower than it.
`timescale 1ns/10ps
`default_nettype none
module tap_sync (
    input wire logic CLK,
    input wire logic RST_N,
    input wire tap_pkg::tap_pins_t pins_in,
    output tap_pkg::tap_pins_t pins_out,
    output tap_pkg::tck_edges_t edges
);
    typedef struct packed {
        tap_pkg::tap_pins_t meta;
        tap_pkg::tap_pins_t sync;
        logic tck_prev;
    } sync_state_t;

    sync_state_t state, next_state;

    always_comb begin
        next_state = state;
        next_state.meta = pins_in;
        next_state.sync = state.meta;
        next_state.tck_prev = state.sync.tck;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pins_out = state.sync;
    // Edges look only at the second stage and its delayed copy
    assign edges = '{
        rise: state.sync.tck & ~state.tck_prev,
        fall: ~state.sync.tck & state.tck_prev
    };
endmodule // tap_sync
`default_nettype wire

// *** rtl/tap_fsm.sv ***
// Sixteen-state test access port controller advanced on test clock rising edges.
// Assumes edge pulses and TMS come from the synchroniser on the same CLK.
`timescale 1ns/10ps
`default_nettype none
module tap_fsm (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic rise,
    input wire logic tms,
    output tap_pkg::tap_state_t tap_state
);
    tap_pkg::tap_state_t next_tap_state;

    always_comb begin
        next_tap_state = tap_state;
        case (tap_state)
            tap_pkg::ST_RESET: next_tap_state = tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE; // [RULE5]
            tap_pkg::ST_IDLE: next_tap_state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: next_tap_state = tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR: next_tap_state = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: next_tap_state = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: next_tap_state = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: next_tap_state = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: next_tap_state = tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR: next_tap_state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: next_tap_state = tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR: next_tap_state = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: next_tap_state = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: next_tap_state = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: next_tap_state = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: next_tap_state = tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR: next_tap_state = tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default: next_tap_state = tap_pkg::ST_RESET;
        endcase
    end

    // State moves only on a test clock rising edge [RULE16] [RULE1]
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tap_state <= tap_pkg::ST_RESET;
        end else if (rise) begin
            tap_state <= next_tap_state;
        end
    end
endmodule // tap_fsm
`default_nettype wire

// *** rtl/tap_scan_timing.sv ***
// Test access port timing core: instruction and data scans with bypass.
// Assumes TCK, TMS, TDI arrive from an external controller, asynchronous
// to CLK, and TCK is slow enough that CLK sees every level (64 ns period).
//
// Summary of operation
// RULE1: Test state moves only on test clock edges.
// RULE2: TDI, TMS, inputs sampled at test clock rise.
// RULE3: TDO and outputs change at test clock fall.
// RULE4: Controller changes TMS on fall, device advances rise.
// RULE5: TMS low leaves reset into run-test idle.
// RULE6: Capture-IR loads pattern 10000001 into shifter.
// RULE7: TDO enables on fall after entering shift.
// RULE8: Shift-IR shifts eight bits, TDI in, TDO out.
// RULE9: TMS high on last bit exits to Exit1.
// RULE10: Last bit shifts on leaving Shift-IR.
// RULE11: Exit1 entry floats TDO on the fall.
// RULE12: Update-IR fall loads instruction; all ones bypass.
// RULE13: Bypass bit captures zero leaving Capture-DR.
// RULE14: Bypass path delays serial data one stage.
// RULE15: Update-DR fall loads data parallel stage.
// RULE16: Full sixteen-state controller, five ones reset.
// RULE17: LSB first; TDO floats outside shift states.
`timescale 1ns/10ps
`default_nettype none
module tap_scan_timing (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic [7:0] FUNC_IN,
    output logic TDO_OUT,
    output logic TDO_OE_N,
    output logic [7:0] FUNC_OUT,
    output logic [7:0] INSTR,
    output logic [7:0] DATA_PAR,
    output logic [15:0] TAP_STATE
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and state machine

    tap_pkg::tap_pins_t pins_raw;
    tap_pkg::tap_pins_t pins_sync;
    tap_pkg::tck_edges_t edges;
    tap_pkg::tap_state_t tap_state;

    assign pins_raw = '{tck: TCK, tms: TMS, tdi: TDI};

    tap_sync u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .pins_in(pins_raw),
        .pins_out(pins_sync),
        .edges(edges)
    );

    tap_fsm u_fsm (
        .CLK(CLK),
        .RST_N(RST_N),
        .rise(edges.rise),
        .tms(pins_sync.tms),
        .tap_state(tap_state)
    );

    ////////////////////////////////////////////////////////////////////////
    // Block state

    typedef struct packed {
        logic [7:0] func_meta;
        logic [7:0] func_sync;
        logic [7:0] ir_shift;
        logic [7:0] instr;
        logic [7:0] dr_shift;
        logic [7:0] dr_par;
        logic bypass;
        logic tdo;
        logic tdo_oe_n;
        logic [7:0] func_out;
        logic [15:0] state_view;
    } core_state_t;

    core_state_t st, next_st;
    logic in_shift_ir;
    logic in_shift_dr;
    logic bypass_sel;
    logic serial_out;

    always_comb begin
        in_shift_ir = (tap_state == tap_pkg::ST_SHIFT_IR);
        in_shift_dr = (tap_state == tap_pkg::ST_SHIFT_DR);
        bypass_sel = (st.instr == tap_pkg::IR_BYPASS);
        // LSB of the active shifter leaves first [RULE17]
        if (in_shift_ir) begin
            serial_out = st.ir_shift[0];
        end else if (bypass_sel) begin
            serial_out = st.bypass;
        end else begin
            serial_out = st.dr_shift[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_st = st;
        // Functional inputs pass two flops before any use
        next_st.func_meta = FUNC_IN;
        next_st.func_sync = st.func_meta;
        // State is reported one cycle behind the controller
        next_st.state_view = tap_state;

        if (edges.rise) begin
            // Inputs captured only at the rising edge [RULE2] [RULE1]
            case (tap_state)
                tap_pkg::ST_CAP_IR: begin
                    next_st.ir_shift = tap_pkg::IR_CAPTURE; // [RULE6]
                end
                tap_pkg::ST_SHIFT_IR: begin
                    // Each rise inside Shift-IR, the exit edge included, moves one bit
                    next_st.ir_shift = {pins_sync.tdi, st.ir_shift[7:1]}; // [RULE8] [RULE9] [RULE10]
                end
                tap_pkg::ST_CAP_DR: begin
                    if (bypass_sel) begin
                        next_st.bypass = tap_pkg::BYPASS_CAPTURE; // [RULE13]
                    end else begin
                        next_st.dr_shift = st.func_sync; // [RULE2]
                    end
                end
                tap_pkg::ST_SHIFT_DR: begin
                    if (bypass_sel) begin
                        next_st.bypass = pins_sync.tdi; // [RULE14] [RULE9]
                    end else begin
                        next_st.dr_shift = {pins_sync.tdi, st.dr_shift[7:1]}; // [RULE17]
                    end
                end
                default: begin
                end
            endcase
        end

        if (edges.fall) begin
            // TDO, its enable and the update loads wait for the falling edge [RULE3] [RULE1]
            // Shift state enables TDO; Exit1 and others float it [RULE7] [RULE11] [RULE17]
            next_st.tdo_oe_n = ~(in_shift_ir | in_shift_dr);
            next_st.tdo = serial_out;
            if (tap_state == tap_pkg::ST_UPD_IR) begin
                next_st.instr = st.ir_shift; // [RULE12]
            end
            if (tap_state == tap_pkg::ST_UPD_DR && !bypass_sel) begin
                next_st.dr_par = st.dr_shift; // [RULE15]
            end
            // Pins follow the parallel stage at the same fall, not one fall late
            next_st.func_out = next_st.dr_par;
        end

        // Reset state restores the bypass instruction
        if (tap_state == tap_pkg::ST_RESET) begin
            next_st.instr = tap_pkg::IR_RESET; // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '{
                func_meta: '0, func_sync: '0,
                ir_shift: '0, instr: tap_pkg::IR_RESET,
                dr_shift: '0, dr_par: tap_pkg::DR_RESET,
                bypass: 1'h0, tdo: 1'h0, tdo_oe_n: 1'h1, func_out: '0,
                state_view: tap_pkg::ST_RESET
            };
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign TDO_OUT = st.tdo;
    assign TDO_OE_N = st.tdo_oe_n;
    assign FUNC_OUT = st.func_out;
    assign INSTR = st.instr;
    assign DATA_PAR = st.dr_par;
    assign TAP_STATE = st.state_view;
endmodule // tap_scan_timing
`default_nettype wire

// *** bench/tap_timing_chk_properties.sv ***
// Checker: pin timing of the test access port against the test clock.
// Assumes TCK is far slower than CLK and every level spans several CLK cycles.
`timescale 1ns/10ps
`default_nettype none
module tap_timing_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TDO_OUT,
    input wire logic TDO_OE_N,
    input wire logic [7:0] INSTR,
    input wire logic [7:0] DATA_PAR,
    input wire logic [15:0] TAP_STATE
);
    // Cycles since TCK last toggled; a late change means a wrong edge
    logic last_tck;
    logic [2:0] cnt;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            last_tck <= 1'b0;
            cnt <= 3'h0;
        end else begin
            last_tck <= TCK;
            cnt <= (TCK != last_tck) ? 3'h0 : ((cnt == 3'h7) ? cnt : cnt + 3'h1);
        end
    end
    // Shift-IR entered straight from Capture-IR; a pause path resumes mid-word
    logic from_capture;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            from_capture <= 1'b0;
        end else if (TAP_STATE == 16'h0400) begin
            from_capture <= 1'b1;
        end else if (TAP_STATE != 16'h0800) begin
            from_capture <= 1'b0;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    tdo_on_fall_a: assert property ($changed(TDO_OUT) |-> !TCK && !last_tck && cnt <= 3'h4)
        else $error("serial output moved outside the falling phase");
    oe_on_fall_a: assert property ($changed(TDO_OE_N) |-> !TCK && !last_tck && cnt <= 3'h4)
        else $error("output enable moved outside the falling phase");
    state_on_rise_a: assert property ($changed(TAP_STATE) |-> TCK && last_tck && cnt <= 3'h4)
        else $error("state moved outside the rising phase");
    state_onehot_a: assert property ($onehot(TAP_STATE))
        else $error("state not one-hot");
    reset_exit_a: assert property ($changed(TAP_STATE) && $past(TAP_STATE) == 16'h0001 |-> TAP_STATE == 16'h0002)
        else $error("reset state left to a wrong state");
    oe_in_shift_a: assert property (!TDO_OE_N |-> (TAP_STATE & 16'h1830) != 16'h0000)
        else $error("output driven outside shift");
    float_exit_a: assert property ($rose(TDO_OE_N) |-> TAP_STATE == 16'h1000 || TAP_STATE == 16'h0020)
        else $error("output floated outside exit1");
    ir_first_bit_a: assert property ($fell(TDO_OE_N) && TAP_STATE == 16'h0800 && from_capture |-> TDO_OUT)
        else $error("first captured instruction bit not one");
    instr_update_a: assert property ($changed(INSTR) |-> TAP_STATE == 16'h8000 || TAP_STATE == 16'h0001)
        else $error("instruction changed outside update");
    data_update_a: assert property ($changed(DATA_PAR) |-> TAP_STATE == 16'h0100)
        else $error("data stage changed outside update");
endmodule // tap_timing_chk
bind tap_scan_timing tap_timing_chk u_chk (.CLK(CLK), .RST_N(RST_N), .TCK(TCK),
    .TDO_OUT(TDO_OUT), .TDO_OE_N(TDO_OE_N), .INSTR(INSTR), .DATA_PAR(DATA_PAR),
    .TAP_STATE(TAP_STATE));
`default_nettype wire

// *** bench/tap_ctl_model.sv ***
// Partner: test controller driving test clock, mode select and serial data.
// Assumes the bench calls bit_cycle once per test clock period.
`timescale 1ns/10ps
`default_nettype none
module tap_ctl_model (
    output logic TCK,
    output logic TMS,
    output logic TDI,
    input wire logic TDO_OUT,
    input wire logic TDO_OE_N
);
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b0;
    end
    // One 64 ns period; TCK rests low between calls
    task automatic bit_cycle(input logic tms, input logic tdi,
                             output logic tdo, output logic oe_n);
        TMS = tms;
        TDI = tdi;
        #30;
        tdo = TDO_OUT;
        oe_n = TDO_OE_N;
        #2 TCK = 1'b1;
        #32 TCK = 1'b0;
    endtask
endmodule // tap_ctl_model
`default_nettype wire

// *** bench/test_tap_scan_timing.sv ***
// Testbench: instruction and data scans, bypass and reset walk.
// Assumes the controller model owns TCK, TMS and TDI.
`timescale 1ns/10ps
`default_nettype none
module test_tap_scan_timing;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] FUNC_IN = 8'h00;
    logic TCK, TMS, TDI, TDO_OUT, TDO_OE_N, tdo, oe;
    logic [7:0] FUNC_OUT, INSTR, DATA_PAR, val, cap, dat;
    logic [15:0] TAP_STATE;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 68;
    always #2.5 CLK = ~CLK;
    tap_scan_timing u_dut (.CLK(CLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI),
        .FUNC_IN(FUNC_IN), .TDO_OUT(TDO_OUT), .TDO_OE_N(TDO_OE_N), .FUNC_OUT(FUNC_OUT),
        .INSTR(INSTR), .DATA_PAR(DATA_PAR), .TAP_STATE(TAP_STATE));
    tap_ctl_model u_ctl (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO_OUT(TDO_OUT),
        .TDO_OE_N(TDO_OE_N));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Bypass stage: each bit comes out one shift late, a zero first
    function automatic logic [7:0] delayed(input logic [7:0] v);
        return {v[6:0], 1'b0};
    endfunction
    task automatic step(input logic tms, input logic tdi);
        u_ctl.bit_cycle(tms, tdi, tdo, oe);
    endtask
    // Idle to idle through one scan; the last bit leaves with TMS high
    task automatic scan(input logic ir, input int w, input logic [7:0] din,
                        input logic [7:0] exp);
        step(1'b1, 1'b0);
        if (ir) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        check("tdo_oe_n", 1'b1, oe);
        step(1'b0, 1'b0);
        for (int i = 0; i < w; i++) begin
            step(i == w - 1, din[i]);
            check("tdo_oe_n", 1'b0, oe);
            check("tdo", exp[i], tdo);
        end
        step(1'b1, 1'b0);
        check("tdo_oe_n", 1'b1, oe);
        step(1'b0, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge CLK);
        @(negedge CLK) RST_N = 1'b1;
        repeat (4) @(negedge CLK);
        #3;
        check("state", 16'h0001, TAP_STATE);
        check("instr", 8'hff, INSTR);
        step(1'b0, 1'b0);
        check("state", 16'h0002, TAP_STATE);
        for (int k = 0; k < 5; k++) begin
            val = (k == 0) ? 8'h00 : (8'($random(seed)) & 8'hfe);
            cap = (k == 0) ? 8'hff : 8'($random(seed));
            dat = 8'($random(seed));
            @(negedge CLK) FUNC_IN = cap;
            scan(1'b1, 8, val, 8'h81);
            check("instr", val, INSTR);
            scan(1'b0, 8, dat, cap);
            check("data_par", dat, DATA_PAR);
            check("func_out", dat, FUNC_OUT);
        end
        scan(1'b1, 8, 8'hff, 8'h81);
        check("instr", 8'hff, INSTR);
        scan(1'b0, 3, 8'h05, delayed(8'h05));
        check("data_par", dat, DATA_PAR);
        scan(1'b1, 8, 8'h3c, 8'h81);
        check("instr", 8'h3c, INSTR);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        repeat (4) step(1'b1, 1'b0);
        check("state", 16'h0200, TAP_STATE);
        step(1'b1, 1'b0);
        check("state", 16'h0001, TAP_STATE);
        check("instr", 8'hff, INSTR);
        print_verdict();
    end
endmodule // test_tap_scan_timing
`default_nettype wire
